// *** src/rgb_link_pkg.sv ***
package rgb_link_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 20;     // pclk at 50 MHz
    localparam int T_PERIOD_MIN_NS  = 1660;   // shortest legal bit period
    localparam int T_PERIOD_MAX_NS  = 50000;  // longest legal bit period
    // least time rounds up, longest time rounds down
    localparam int PERIOD_MIN_CYC   = (T_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERIOD_MAX_CYC   = T_PERIOD_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          APB_AW        = 12;
    localparam int          APB_DW        = 32;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;  // hold multiples
    localparam logic [11:0] ADDR_STATUS   = 12'h004;  // receiver state
    localparam logic [11:0] ADDR_GRAY     = 12'h008;  // grayscale latch
    localparam logic [11:0] ADDR_SHIFT    = 12'h00C;  // packet shift register
    localparam logic [11:0] ADDR_LUT_IDX  = 12'h010;  // lookup table index
    localparam logic [11:0] ADDR_LUT_DATA = 12'h014;  // lookup table entry

    // ------------------------------------------------------------
    // control field layout and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_EOS_LSB  = 0;
    localparam int         CTRL_LAT_LSB  = 4;
    localparam logic [3:0] EOS_MULT_RST  = 4'h4;  // packet_end_hold in bit periods
    localparam logic [3:0] LAT_MULT_RST  = 4'h8;  // latch_hold in bit periods

    // ------------------------------------------------------------
    // packet layout
    // ------------------------------------------------------------
    localparam int         PKT_W         = 32;
    localparam int         GRAY_W        = 24;
    localparam int         CH_A_LSB      = 16;    // gray_value_ch_a
    localparam int         CH_B_LSB      = 8;     // gray_value_ch_b
    localparam int         CH_C_LSB      = 0;     // gray_value_ch_c
    localparam int         CMD_LSB       = 24;    // write_code_byte
    localparam logic [7:0] WRITE_CODE    = 8'h3A;
    localparam logic [23:0] GRAY_RST     = 24'h000000;

    // ------------------------------------------------------------
    // receiver states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_WAIT_FIRST = 4'b0001,  // waiting for first rising edge
        S_MEASURE    = 4'b0010,  // timing the bit period
        S_BITS       = 4'b0100,  // decoding data bits
        S_FORWARD    = 4'b1000   // packet locked, passing line on
    } rx_state_t;

endpackage

// *** src/sink_channel_pwm.sv ***
// one sink channel: compares the grayscale counter with its threshold
module sink_channel_pwm #(
    parameter int CNT_W = 11
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // counter and channel data
    input  wire logic [CNT_W-1:0] gs_cnt,
    input  wire logic [7:0]       gray_value,
    input  wire logic [CNT_W-1:0] off_thr,
    input  wire logic             force_off,
    // output
    output logic                  sink_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic on;  // registered drive level
    } ch_st_t;

    ch_st_t st_r;    // current state
    ch_st_t st_nxt;  // next state

    // on from count one up to the threshold; zero data never lights
    always_comb begin
        st_nxt    = st_r;
        st_nxt.on = !force_off && (gray_value != 8'h00) &&
                    (gs_cnt != '0) && (gs_cnt <= off_thr);
    end

    // register, off at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sink_out = st_r.on;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_on_window;
        @(posedge pclk) disable iff (!presetn)
        (!force_off && gray_value != 8'h00 && gs_cnt != '0 && gs_cnt <= off_thr) |=> sink_out;
    endproperty
    a_on_window: assert property (p_on_window) else $error("channel not on inside window");

    property p_off_above;
        @(posedge pclk) disable iff (!presetn)
        (gs_cnt > off_thr) |=> !sink_out;
    endproperty
    a_off_above: assert property (p_off_above) else $error("channel on above threshold");

endmodule

// *** src/one_wire_rgb_pwm_receiver.sv ***
// Function
// - output on while counter at most value; here at most the table entry for value, a linear ramp after reset
// - output off once counter exceeds value; here once it exceeds the table entry for value
// - first two rising edges set bit period
// - measurement shifts in two zero bits
// - edge before half period means one
// - end idle freezes packet, forwards line
// - latch idle copies data, restarts pwm
// - packet is 32 bits, msb first
// - latch copies only with write code
// - fixed bit positions per channel, command
// - outputs off until data latched
// - latch clears counter, forces outputs off
// - nonzero channels turn on at one
// - counter advances on reference clock
//
// Chosen here: the placing of the registers and register access over APB.
module one_wire_rgb_pwm_receiver #(
    parameter int PERIOD_W = 16,  // bit period counter width
    parameter int GS_CNT_W = 11,  // grayscale counter width
    parameter int GS_DIV   = 8    // pclk cycles per reference tick
) (
    // clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [rgb_link_pkg::APB_AW-1:0]  paddr,
    input  wire logic [rgb_link_pkg::APB_DW-1:0]  pwdata,
    output logic      [rgb_link_pkg::APB_DW-1:0]  prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // serial link
    input  wire logic                             serial_line_in,
    output logic                                  chain_line_out,
    // sink outputs
    output logic                                  sink_out_a,
    output logic                                  sink_out_b,
    output logic                                  sink_out_c
);
    import rgb_link_pkg::*;

    localparam int LOW_W = 24;  // idle counter width

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                sync1;      // synchroniser stage one
        logic                sync2;      // synchroniser stage two
        logic                sin_q;      // delayed copy for edge detect
        rx_state_t           state;      // receiver state
        logic [PERIOD_W-1:0] period;     // bit_period_ref
        logic                pvalid;     // a period has been measured
        logic [PERIOD_W-1:0] since;      // cycles since last rising edge
        logic [LOW_W-1:0]    low_cnt;    // cycles the line has been low
        logic [PKT_W-1:0]    sr;         // packet shift register
        logic [GRAY_W-1:0]   gray;       // grayscale latch
        logic [GS_CNT_W-1:0] gs_cnt;     // pwm counter
        logic [7:0]          gs_div;     // reference clock divider
        logic                gs_tick;    // gray_ref_clock pulse
        logic                force_off;  // outputs held off after latch
        logic [3:0]          eos_mult;   // packet_end_hold multiple
        logic [3:0]          lat_mult;   // latch_hold multiple
        logic [7:0]          lut_idx;    // table index for apb access
        logic                chain;      // chain_line_out
        logic [APB_DW-1:0]   rdata;      // read data
        logic                slverr;     // error answer
    } st_t;

    st_t st_r;    // current state
    st_t st_nxt;  // next state

    logic [GS_CNT_W-1:0] lut_r [256];  // gamma threshold table

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // idle hold in pclk cycles from period and multiple
    function automatic logic [LOW_W-1:0] hold_cycles(input logic [PERIOD_W-1:0] p, input logic [4:0] m);
        hold_cycles = LOW_W'(p) * LOW_W'(m);
    endfunction

    logic             rise;      // rising edge on synchronised line
    logic [4:0]       eos_m;     // effective end-of-packet multiple
    logic [4:0]       lat_m;     // effective latch multiple
    logic [LOW_W-1:0] eos_thr;   // packet_end_hold in cycles
    logic [LOW_W-1:0] lat_thr;   // latch_hold in cycles
    logic             eos_hit;   // packet end idle seen
    logic             lat_hit;   // latch idle seen
    logic             bit_one;   // decoded data value
    logic             cmd_ok;    // command byte matches write code
    logic             period_ok; // measured period is legal
    logic             apb_wr;    // write access phase
    logic             apb_setup; // setup phase
    logic             addr_ok;   // address is mapped

    assign rise    = st_r.sync2 & ~st_r.sin_q;
    assign eos_m   = {1'b0, st_r.eos_mult};
    // latch hold always strictly longer than the packet end hold
    assign lat_m   = (st_r.lat_mult > st_r.eos_mult) ? {1'b0, st_r.lat_mult} : eos_m + 5'h01;
    assign eos_thr = hold_cycles(st_r.period, eos_m);
    assign lat_thr = hold_cycles(st_r.period, lat_m);
    assign eos_hit = (st_r.state == S_BITS) && !st_r.sync2 && (st_r.low_cnt >= eos_thr);
    // equality makes the latch a single event per idle stretch
    assign lat_hit = ((st_r.state == S_BITS) || (st_r.state == S_FORWARD)) &&
                     !st_r.sync2 && (st_r.low_cnt == lat_thr);
    assign bit_one = st_r.since < (st_r.period >> 1);
    assign cmd_ok  = st_r.sr[CMD_LSB +: 8] == WRITE_CODE;
    assign period_ok = (st_r.period >= PERIOD_W'(PERIOD_MIN_CYC)) &&
                       (st_r.period <= PERIOD_W'(PERIOD_MAX_CYC));
    assign apb_wr    = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    assign addr_ok   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_GRAY) ||
                       (paddr == ADDR_SHIFT) || (paddr == ADDR_LUT_IDX) || (paddr == ADDR_LUT_DATA);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // two flops before any logic looks at the pin
        st_nxt.sync1 = serial_line_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sin_q = st_r.sync2;
        // edge-to-edge timer from one, so an edge reads the whole gap; saturates
        if (rise) begin
            st_nxt.since = PERIOD_W'(1);
        end else if (st_r.since != '1) begin
            st_nxt.since = st_r.since + 1'b1;
        end
        // low-time timer for both idle holds
        if (st_r.sync2) begin
            st_nxt.low_cnt = '0;
        end else if (st_r.low_cnt != '1) begin
            st_nxt.low_cnt = st_r.low_cnt + 1'b1;
        end
        // receiver sequencing
        case (st_r.state)
            S_WAIT_FIRST: begin
                if (rise) begin
                    st_nxt.state = S_MEASURE;
                end
            end
            S_MEASURE: begin
                if (rise) begin
                    st_nxt.period = st_r.since;
                    st_nxt.pvalid = 1'b1;
                    st_nxt.sr     = {st_r.sr[PKT_W-3:0], 2'b00};
                    st_nxt.state  = S_BITS;
                end else if (st_r.since >= PERIOD_W'(PERIOD_MAX_CYC)) begin
                    // too slow to be a bit period: start over
                    st_nxt.state = S_WAIT_FIRST;
                end
            end
            S_BITS: begin
                if (rise) begin
                    // msb arrives first and ends up at the top
                    st_nxt.sr = {st_r.sr[PKT_W-2:0], bit_one};
                end else if (eos_hit) begin
                    st_nxt.state = S_FORWARD;
                end
            end
            // shift register frozen; only the latch idle leaves here
            S_FORWARD: st_nxt.state = S_FORWARD;
            default:   st_nxt.state = S_WAIT_FIRST;
        endcase
        // buffered copy of the line once the packet is locked
        st_nxt.chain = (st_r.state == S_FORWARD) ? st_r.sync2 : 1'b0;
        // reference clock divider
        st_nxt.gs_tick = 1'b0;
        if (st_r.gs_div == 8'(GS_DIV - 1)) begin
            st_nxt.gs_div  = 8'h00;
            st_nxt.gs_tick = 1'b1;
        end else begin
            st_nxt.gs_div = st_r.gs_div + 8'h01;
        end
        if (st_r.gs_tick) begin
            st_nxt.gs_cnt    = st_r.gs_cnt + 1'b1;
            st_nxt.force_off = 1'b0;
        end
        // latch idle wins over everything else in this cycle
        if (lat_hit) begin
            st_nxt.state = S_WAIT_FIRST;
            if (cmd_ok) begin
                st_nxt.gray = st_r.sr[GRAY_W-1:0];
            end
            st_nxt.gs_cnt    = '0;
            st_nxt.gs_div    = 8'h00;
            st_nxt.gs_tick   = 1'b0;
            st_nxt.force_off = 1'b1;
        end
        // register writes take effect in the access phase
        if (apb_wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    st_nxt.eos_mult = pwdata[CTRL_EOS_LSB +: 4];
                    st_nxt.lat_mult = pwdata[CTRL_LAT_LSB +: 4];
                end
                ADDR_LUT_IDX: st_nxt.lut_idx = pwdata[7:0];
                default:      st_nxt.lut_idx = st_r.lut_idx;
            endcase
        end
        // read data and error captured in setup, shown in access
        if (apb_setup) begin
            st_nxt.slverr = !addr_ok;
            case (paddr)
                ADDR_CTRL:     st_nxt.rdata = 32'({st_r.lat_mult, st_r.eos_mult});
                ADDR_STATUS:   st_nxt.rdata = 32'({st_r.chain, st_r.state, period_ok, st_r.pvalid, st_r.period});
                ADDR_GRAY:     st_nxt.rdata = 32'(st_r.gray);
                ADDR_SHIFT:    st_nxt.rdata = st_r.sr;
                ADDR_LUT_IDX:  st_nxt.rdata = 32'(st_r.lut_idx);
                ADDR_LUT_DATA: st_nxt.rdata = 32'(lut_r[st_r.lut_idx]);
                default:       st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.state    <= S_WAIT_FIRST;
            st_r.gray     <= GRAY_RST;
            st_r.eos_mult <= EOS_MULT_RST;
            st_r.lat_mult <= LAT_MULT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // table defaults to a linear ramp; software reloads a gamma curve
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 256; i++) begin
                lut_r[i] <= GS_CNT_W'(i);
            end
        end else if (apb_wr && (paddr == ADDR_LUT_DATA)) begin
            lut_r[st_r.lut_idx] <= pwdata[GS_CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // outputs and channels
    // ------------------------------------------------------------
    assign prdata         = st_r.rdata;
    assign pslverr        = st_r.slverr;
    assign pready         = 1'b1;  // zero wait states
    assign chain_line_out = st_r.chain;

    sink_channel_pwm #(.CNT_W(GS_CNT_W)) u_ch_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .gs_cnt     (st_r.gs_cnt),
        .gray_value (st_r.gray[CH_A_LSB +: 8]),
        .off_thr    (lut_r[st_r.gray[CH_A_LSB +: 8]]),
        .force_off  (st_r.force_off),
        .sink_out   (sink_out_a)
    );
    sink_channel_pwm #(.CNT_W(GS_CNT_W)) u_ch_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .gs_cnt     (st_r.gs_cnt),
        .gray_value (st_r.gray[CH_B_LSB +: 8]),
        .off_thr    (lut_r[st_r.gray[CH_B_LSB +: 8]]),
        .force_off  (st_r.force_off),
        .sink_out   (sink_out_b)
    );
    sink_channel_pwm #(.CNT_W(GS_CNT_W)) u_ch_c (
        .pclk       (pclk),
        .presetn    (presetn),
        .gs_cnt     (st_r.gs_cnt),
        .gray_value (st_r.gray[CH_C_LSB +: 8]),
        .off_thr    (lut_r[st_r.gray[CH_C_LSB +: 8]]),
        .force_off  (st_r.force_off),
        .sink_out   (sink_out_c)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_period_capture;
        (st_r.state == S_MEASURE && rise) |=> (st_r.period == $past(st_r.since) && st_r.state == S_BITS);
    endproperty
    a_period_capture: assert property (p_period_capture) else $error("period not captured");
    property p_two_zeros;
        (st_r.state == S_MEASURE && rise) |=> (st_r.sr[1:0] == 2'b00 && st_r.sr[31:2] == $past(st_r.sr[29:0]));
    endproperty
    a_two_zeros: assert property (p_two_zeros) else $error("measurement did not shift two zeros");
    property p_bit_one;
        (st_r.state == S_BITS && rise && st_r.since < (st_r.period >> 1)) |=> st_r.sr[0];
    endproperty
    a_bit_one: assert property (p_bit_one) else $error("early edge not decoded as one");
    property p_bit_zero;
        (st_r.state == S_BITS && rise && st_r.since >= (st_r.period >> 1)) |=> !st_r.sr[0];
    endproperty
    a_bit_zero: assert property (p_bit_zero) else $error("late edge not decoded as zero");
    property p_forward;
        (st_r.state == S_FORWARD) |=> (chain_line_out == $past(st_r.sync2) && $stable(st_r.sr));
    endproperty
    a_forward: assert property (p_forward) else $error("forwarding or freeze broken");
    property p_latch_copy;
        (lat_hit && cmd_ok) |=> (st_r.gray == $past(st_r.sr[23:0]) && st_r.state == S_WAIT_FIRST);
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("grayscale not latched");
    property p_latch_reject;
        (lat_hit && !cmd_ok) |=> $stable(st_r.gray);
    endproperty
    a_latch_reject: assert property (p_latch_reject) else $error("bad command changed latch");
    property p_latch_restart;
        lat_hit |=> (st_r.gs_cnt == '0 && st_r.force_off) ##1 (!sink_out_a && !sink_out_b && !sink_out_c);
    endproperty
    a_latch_restart: assert property (p_latch_restart) else $error("pwm not restarted on latch");
    property p_dark_when_zero;
        (st_r.gray == GRAY_RST) |=> (!sink_out_a && !sink_out_b && !sink_out_c);
    endproperty
    a_dark_when_zero: assert property (p_dark_when_zero) else $error("output lit with zero data");
    property p_eos_before_latch;
        eos_hit |=> (st_r.state == S_FORWARD) ##0 (lat_thr > eos_thr);
    endproperty
    a_eos_before_latch: assert property (p_eos_before_latch) else $error("end idle handling wrong");

endmodule

// *** tb/serial_host_model.sv ***
// host side of the single-wire link: times rising edges on the line
module serial_host_model #(
    parameter int BIT_P  = 100,  // bit period in pclk cycles
    parameter int HIGH_W = 8     // high pulse width, kept below BIT_P/4
) (
    // clock
    input  wire logic pclk,
    // line toward the receiver
    output logic      serial_line_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial serial_line_in = 1'b0;

    // one rising edge a given gap after the last one; low again quickly
    task automatic edge_after(input int gap);
        repeat (gap - HIGH_W) @(posedge pclk);
        serial_line_in <= 1'b1;
        repeat (HIGH_W) @(posedge pclk);
        serial_line_in <= 1'b0;
    endtask

    // two timing edges, then thirty bits msb first; top two bits must be 0
    task automatic send_packet(input logic [31:0] pkt);
        edge_after(BIT_P);
        edge_after(BIT_P);
        for (int i = 29; i >= 0; i--) begin
            edge_after(pkt[i] ? BIT_P / 4 : BIT_P);
        end
    endtask

    // line held low: packet end or latch idle, chosen by the caller
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
endmodule

// *** tb/one_wire_rgb_pwm_receiver_test.sv ***
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module one_wire_rgb_pwm_receiver_test import rgb_link_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 100;  // bit period in cycles
    localparam int DIV = 2;  // short reference tick for simulation
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, chain_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, pkt;
    logic        serial_line_in, chain_line_out, sink_out_a, sink_out_b, sink_out_c;
    logic [23:0] m_gray;  // model of the grayscale latch
    int          miscompares, n_checks, chain_edges, ca, cb, cc;
    int          m_lut [256];  // model of the threshold table
    // expected on-cycles of one channel over a full counter wrap
    function automatic int exp_on(input logic [7:0] v);
        return (v != 8'h00) ? DIV * m_lut[v] : 0;
    endfunction

    one_wire_rgb_pwm_receiver #(.GS_DIV(DIV)) one_wire_rgb_pwm_receiver_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_line_in(serial_line_in), .chain_line_out(chain_line_out),
        .sink_out_a(sink_out_a), .sink_out_b(sink_out_b), .sink_out_c(sink_out_c));
    serial_host_model #(.BIT_P(P)) serial_host_model_i (.pclk(pclk), .serial_line_in(serial_line_in));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // rising edges seen on the chain output
    always @(posedge pclk) begin
        chain_q <= chain_line_out;
        if (chain_line_out === 1'b1 && chain_q === 1'b0) chain_edges++;
    end

    // one apb transfer; waits for pready, only the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // on-cycles of each sink over one full counter wrap
    task automatic count_on();
        ca = 0; cb = 0; cc = 0;
        repeat (2048 * DIV) begin
            @(posedge pclk);
            ca += (sink_out_a === 1'b1); cb += (sink_out_b === 1'b1); cc += (sink_out_c === 1'b1);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        end_sim();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        miscompares = 0; n_checks = 0; chain_edges = 0; m_gray = '0;
        foreach (m_lut[i]) m_lut[i] = i;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(10));
        apb(1'b0, ADDR_CTRL, 32'h0);    `CHK("ctrl reset", 32'h84, rd)
        apb(1'b1, ADDR_CTRL, 32'h95);
        apb(1'b0, ADDR_CTRL, 32'h0);    `CHK("ctrl rw", 32'h95, rd)
        apb(1'b1, ADDR_CTRL, 32'h84);
        apb(1'b0, 12'hFF0, 32'h0);      `CHK("unmapped err", 1'b1, er)
        count_on();                     `CHK("dark at start", 0, ca + cb + cc)
        $display("test reset done");
        for (int t = 0; t < 2; t++) begin
            // a good command first, then a wrong code that must be ignored
            pkt = {t ? 8'h3B : WRITE_CODE, 24'($urandom)};
            // steeper entry for channel a's byte, read back over the bus
            m_lut[pkt[23:16]] = 2 * pkt[23:16] + 1;
            apb(1'b1, ADDR_LUT_IDX, {24'h000000, pkt[23:16]});
            apb(1'b1, ADDR_LUT_DATA, m_lut[pkt[23:16]]);
            apb(1'b0, ADDR_LUT_DATA, 32'h0);  `CHK("lut", m_lut[pkt[23:16]], rd)
            serial_host_model_i.send_packet(pkt);
            serial_host_model_i.idle(4 * P + 50);
            apb(1'b0, ADDR_SHIFT, 32'h0);   `CHK("shift", pkt, rd)
            apb(1'b0, ADDR_STATUS, 32'h0);
            `CHK("period", 17'h10000 | P, rd[16:0])
            `CHK("forward state", 4'h8, rd[21:18])
            `CHK("chain quiet", 0, chain_edges)
            serial_host_model_i.send_packet({2'b00, 30'($urandom)});
            serial_host_model_i.idle(4 * P + 50);
            `CHK("chain edges", 32, chain_edges)
            serial_host_model_i.idle(4 * P + 50);
            if (pkt[31:24] == WRITE_CODE) m_gray = pkt[23:0];
            apb(1'b0, ADDR_GRAY, 32'h0);    `CHK("gray", {8'h0, m_gray}, rd)
            repeat (20) @(posedge pclk);
            count_on();
            `CHK("on a", exp_on(m_gray[CH_A_LSB+:8]), ca)
            `CHK("on b", exp_on(m_gray[CH_B_LSB+:8]), cb)
            `CHK("on c", exp_on(m_gray[CH_C_LSB+:8]), cc)
            chain_edges = 0;
            $display("test packet %0d done", t);
        end
        end_sim();
    end
endmodule
